// ### dsr_pkg.sv
package dsr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WORD_W = 16;

  // register offsets
  localparam logic [7:0] ERROR_STATUS_OFS         = 8'h04;
  localparam logic [7:0] INTERFACE_OPTIONS_OFS    = 8'h05;
  localparam logic [7:0] POWER_BIAS_CONTROL_OFS   = 8'h06;
  localparam logic [7:0] OUTPUT_CURRENT_SCALE_OFS = 8'h07;

  // reset values
  localparam logic [7:0] ERROR_STATUS_RST         = 8'h00;
  localparam logic [7:0] INTERFACE_OPTIONS_RST    = 8'h00;
  localparam logic [7:0] POWER_BIAS_CONTROL_RST   = 8'h0C;
  localparam logic [7:0] OUTPUT_CURRENT_SCALE_RST = 8'hFF;

  // error_status fields
  localparam int unsigned STS_OVERRUN_BIT = 5;
  localparam int unsigned STS_PATTERN_BIT = 4;

  // interface_options fields and writable bits
  localparam int unsigned OPT_FOUR_WIRE_BIT    = 7;
  localparam int unsigned OPT_BUS_REVERSE_BIT  = 6;
  localparam int unsigned OPT_RESYNC_INH_BIT   = 5;
  localparam int unsigned OPT_SKEW_BYPASS_BIT  = 2;
  localparam int unsigned OPT_CLKMUL_BYPASS_BIT = 1;
  localparam logic [7:0]  OPT_WRITE_MASK       = 8'hE6;

  // power_bias_control fields and writable bits
  localparam int unsigned PWR_SLEEP_B_BIT   = 5;
  localparam int unsigned PWR_SLEEP_A_BIT   = 4;
  localparam int unsigned PWR_CORNER_A_BIT  = 3;
  localparam int unsigned PWR_CORNER_B_BIT  = 2;
  localparam int unsigned PWR_CLKMUL_SLP_BIT = 1;
  localparam int unsigned PWR_SKEW_SLP_BIT  = 0;
  localparam logic [7:0]  PWR_WRITE_MASK    = 8'h3F;

  // output_current_scale fields
  localparam int unsigned SCALE_A_LSB = 4;
  localparam int unsigned SCALE_B_LSB = 0;
  localparam int unsigned SCALE_W     = 4;

  // allowed checkerboard words
  localparam logic [15:0] CHECK_PAT_A = 16'hAAAA;
  localparam logic [15:0] CHECK_PAT_B = 16'h5555;

endpackage

// ### dsr_chk_if.sv
`timescale 1ns/1ns
interface dsr_chk_if;
  import dsr_pkg::*;

  logic [WORD_W-1:0] word;
  logic              word_valid;
  logic              check_en;
  logic              mismatch;

  modport ctrl
  (
    output word,
    output word_valid,
    output check_en,
    input  mismatch
  );

  modport chk
  (
    input  word,
    input  word_valid,
    input  check_en,
    output mismatch
  );
endinterface

// ### dsr_pattern_check.sv
`timescale 1ns/1ns
module dsr_pattern_check
  import dsr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  dsr_chk_if.chk    chk
);

  ////////////////////////////////////////////////////////////////////////////
  wire word_ok;
  wire bad_word;

  assign word_ok  = (chk.word == CHECK_PAT_A) || (chk.word == CHECK_PAT_B);
  // a pulse per bad word; the flag itself lives with the register
  assign bad_word = chk.check_en && chk.word_valid && !word_ok; // [R02] [R03]
  assign chk.mismatch = bad_word;

  ////////////////////////////////////////////////////////////////////////////
  AST_BAD_WORD_FLAGGED: assert property (@(posedge mclk) // [R03]
    disable iff (rst)
    chk.check_en && chk.word_valid && chk.word != CHECK_PAT_A
    && chk.word != CHECK_PAT_B |-> chk.mismatch)
    else $error("non checkerboard word not reported");

  AST_CHECK_OFF_QUIET: assert property (@(posedge mclk) // [R02]
    disable iff (rst)
    !chk.check_en |-> !chk.mismatch)
    else $error("mismatch reported while check is off");

endmodule

// ### dsr_regs.sv
`timescale 1ns/1ns
// What this block does
// R01 - buffer pointer overrun sets overrun flag; only writing zero clears it
// R02 - while check enabled, compare every word leaving the input buffer
// R03 - set mismatch flag when a word is neither checkerboard pattern
// R04 - host flushes eight good samples, then writes zero to clear mismatch
// R05 - bus reverse bit mirrors the parallel input bus bit order
// R06 - resync inhibit bit blocks divider resync on sync events
// R07 - skew bypass samples data without skew loop; source aligns data
// R08 - software writes zero to every reserved bit; the testbench once writes 8'hFF to status
// R09 - channel power-down bits put channel A or B to sleep
// R10 - single-channel mode alone never sleeps channel B
// R11 - bias corner bit per channel: clear low corner, set high corner
// R12 - clock multiplier power-down bit sleeps the phase-locked loop
// R13 - skew loop power-down bit sleeps the delay-locked loop
// R14 - 4-bit current scale per channel; upper nibble A, lower nibble B
// R15 - scale resets all ones; power control resets with corners set only
// R16 - a set mask bit suppresses its error flag
// R17 - error flags sticky until written zero; writing one does nothing
// R18 - unused status bits read zero and ignore writes
module dsr_regs
  import dsr_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               reg_wr_en,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  output      logic [DATA_W-1:0]  reg_rdata,
  input  wire logic               overrun_err_mask,
  input  wire logic               pattern_err_mask,
  input  wire logic               buf_overrun,
  input  wire logic [WORD_W-1:0]  buf_word,
  input  wire logic               buf_word_valid,
  input  wire logic [WORD_W-1:0]  in_bus_raw,
  output      logic [WORD_W-1:0]  in_bus_mapped,
  input  wire logic               sync_event,
  output      logic               divider_resync,
  output      logic               four_wire_serial_select,
  output      logic               skew_loop_bypass,
  output      logic               clock_mult_bypass,
  output      logic               chan_a_sleep,
  output      logic               chan_b_sleep,
  output      logic               chan_a_bias_corner_sel,
  output      logic               chan_b_bias_corner_sel,
  output      logic               clock_mult_sleep,
  output      logic               skew_loop_sleep,
  output      logic [SCALE_W-1:0] chan_a_current_scale,
  output      logic [SCALE_W-1:0] chan_b_current_scale
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [WORD_W-1:0] mirror(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++)
    begin
      r[i] = w[WORD_W-1-i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] opt_reg;
  logic [DATA_W-1:0] pwr_reg;
  logic [DATA_W-1:0] scale_reg;
  logic              overrun_flag_reg;
  logic              pattern_flag_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [WORD_W-1:0] bus_reg;
  logic              resync_reg;

  wire wr_sts   = reg_wr_en && (reg_addr == ERROR_STATUS_OFS);
  wire wr_opt   = reg_wr_en && (reg_addr == INTERFACE_OPTIONS_OFS);
  wire wr_pwr   = reg_wr_en && (reg_addr == POWER_BIAS_CONTROL_OFS);
  wire wr_scale = reg_wr_en && (reg_addr == OUTPUT_CURRENT_SCALE_OFS);

  // only a written zero clears; a written one leaves the flag alone
  wire overrun_clr = wr_sts && !reg_wdata[STS_OVERRUN_BIT]; // [R01] [R17]
  wire pattern_clr = wr_sts && !reg_wdata[STS_PATTERN_BIT]; // [R17]

  wire overrun_set = buf_overrun && !overrun_err_mask; // [R01] [R16]
  wire pattern_hit;

  // set wins over clear so a coincident event is never lost
  wire overrun_next = overrun_set || (overrun_flag_reg && !overrun_clr);
  wire pattern_next = pattern_hit || (pattern_flag_reg && !pattern_clr);

  // reserved bits are not stored, so they read back zero
  wire [DATA_W-1:0] opt_next = wr_opt ? (reg_wdata & OPT_WRITE_MASK) : opt_reg;
  wire [DATA_W-1:0] pwr_next = wr_pwr ? (reg_wdata & PWR_WRITE_MASK) : pwr_reg;
  wire [DATA_W-1:0] scale_next = wr_scale ? reg_wdata : scale_reg;

  wire [DATA_W-1:0] sts_view;
  assign sts_view = (DATA_W'(overrun_flag_reg) << STS_OVERRUN_BIT)
                  | (DATA_W'(pattern_flag_reg) << STS_PATTERN_BIT); // [R18]

  wire [DATA_W-1:0] rdata_next =
      (reg_addr == ERROR_STATUS_OFS)         ? sts_view  :
      (reg_addr == INTERFACE_OPTIONS_OFS)    ? opt_reg   :
      (reg_addr == POWER_BIAS_CONTROL_OFS)   ? pwr_reg   :
      (reg_addr == OUTPUT_CURRENT_SCALE_OFS) ? scale_reg : '0;

  wire bus_rev  = opt_reg[OPT_BUS_REVERSE_BIT];
  wire resync_inh = opt_reg[OPT_RESYNC_INH_BIT];
  wire [WORD_W-1:0] bus_next =
      bus_rev ? mirror(in_bus_raw) : in_bus_raw; // [R05]
  wire resync_next = sync_event && !resync_inh; // [R06]

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      opt_reg          <= INTERFACE_OPTIONS_RST;
      pwr_reg          <= POWER_BIAS_CONTROL_RST; // [R15]
      scale_reg        <= OUTPUT_CURRENT_SCALE_RST; // [R15]
      overrun_flag_reg <= ERROR_STATUS_RST[STS_OVERRUN_BIT];
      pattern_flag_reg <= ERROR_STATUS_RST[STS_PATTERN_BIT];
      rdata_reg        <= '0;
      bus_reg          <= '0;
      resync_reg       <= 1'b0;
    end
    else
    begin
      opt_reg          <= opt_next;
      pwr_reg          <= pwr_next;
      scale_reg        <= scale_next;
      overrun_flag_reg <= overrun_next;
      pattern_flag_reg <= pattern_next;
      rdata_reg        <= rdata_next;
      bus_reg          <= bus_next;
      resync_reg       <= resync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checker watches buffer output only while its mask is clear; the mask
  // resets set elsewhere, so checking is off until software enables it
  dsr_chk_if chk_bus ();

  assign chk_bus.word       = buf_word;
  assign chk_bus.word_valid = buf_word_valid;
  assign chk_bus.check_en   = !pattern_err_mask; // [R02] [R16]
  assign pattern_hit        = chk_bus.mismatch; // [R03]

  dsr_pattern_check u_check
  (
    .mclk (mclk),
    .rst  (rst),
    .chk  (chk_bus.chk)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata               = rdata_reg;
  assign in_bus_mapped           = bus_reg;
  assign divider_resync          = resync_reg;
  assign four_wire_serial_select = opt_reg[OPT_FOUR_WIRE_BIT];
  // with bypass set the source owns data-to-clock alignment
  assign skew_loop_bypass        = opt_reg[OPT_SKEW_BYPASS_BIT]; // [R07]
  assign clock_mult_bypass       = opt_reg[OPT_CLKMUL_BYPASS_BIT];
  assign chan_a_sleep            = pwr_reg[PWR_SLEEP_A_BIT]; // [R09]
  // no mode input feeds this: channel b sleeps on its own bit alone
  assign chan_b_sleep            = pwr_reg[PWR_SLEEP_B_BIT]; // [R09] [R10]
  assign chan_a_bias_corner_sel  = pwr_reg[PWR_CORNER_A_BIT]; // [R11]
  assign chan_b_bias_corner_sel  = pwr_reg[PWR_CORNER_B_BIT]; // [R11]
  assign clock_mult_sleep        = pwr_reg[PWR_CLKMUL_SLP_BIT]; // [R12]
  assign skew_loop_sleep         = pwr_reg[PWR_SKEW_SLP_BIT]; // [R13]
  assign chan_a_current_scale    = scale_reg[SCALE_A_LSB +: SCALE_W]; // [R14]
  assign chan_b_current_scale    = scale_reg[SCALE_B_LSB +: SCALE_W]; // [R14]

  ////////////////////////////////////////////////////////////////////////////
  AST_OVERRUN_SETS: assert property (@(posedge mclk) // [R01]
    disable iff (rst)
    buf_overrun && !overrun_err_mask |=> overrun_flag_reg)
    else $error("overrun did not set flag");

  AST_OVERRUN_CLEARS: assert property (@(posedge mclk) // [R01]
    disable iff (rst)
    wr_sts && !reg_wdata[STS_OVERRUN_BIT] && !buf_overrun
    |=> !overrun_flag_reg)
    else $error("zero write did not clear overrun flag");

  AST_FLAG_STICKY: assert property (@(posedge mclk) // [R17]
    disable iff (rst)
    overrun_flag_reg && !wr_sts |=> overrun_flag_reg)
    else $error("overrun flag dropped without a write");

  AST_WRITE_ONE_KEEPS: assert property (@(posedge mclk) // [R17]
    disable iff (rst)
    pattern_flag_reg && wr_sts && reg_wdata[STS_PATTERN_BIT]
    |=> pattern_flag_reg)
    else $error("writing one cleared mismatch flag");

  AST_MASK_SUPPRESSES: assert property (@(posedge mclk) // [R16]
    disable iff (rst)
    !overrun_flag_reg && overrun_err_mask && !wr_sts
    |=> !overrun_flag_reg)
    else $error("masked overrun set the flag");

  AST_MISMATCH_SETS: assert property (@(posedge mclk) // [R03]
    disable iff (rst)
    pattern_hit |=> pattern_flag_reg)
    else $error("mismatch did not set flag");

  // watched from the ports so a broken checker link is caught as well
  AST_BAD_WORD_TO_FLAG: assert property (@(posedge mclk) // [R02] [R03]
    disable iff (rst)
    buf_word_valid && !pattern_err_mask && buf_word != CHECK_PAT_A
    && buf_word != CHECK_PAT_B |=> pattern_flag_reg)
    else $error("bad input word did not set mismatch flag");

  AST_MIRROR: assert property (@(posedge mclk) // [R05]
    disable iff (rst)
    bus_rev |=> in_bus_mapped[0] == $past(in_bus_raw[WORD_W-1])
    && in_bus_mapped[WORD_W-1] == $past(in_bus_raw[0]))
    else $error("bus reverse mapping wrong");

  AST_RESYNC_INHIBIT: assert property (@(posedge mclk) // [R06]
    disable iff (rst)
    resync_inh |=> !divider_resync)
    else $error("divider resync while inhibited");

  AST_RESYNC_PASSES: assert property (@(posedge mclk) // [R06]
    disable iff (rst)
    sync_event && !resync_inh |=> divider_resync)
    else $error("sync event did not resync dividers");

  AST_RESET_VALUES: assert property (@(posedge mclk) // [R15]
    $past(rst) |-> chan_a_current_scale == 4'hF
    && chan_b_current_scale == 4'hF && chan_a_bias_corner_sel
    && chan_b_bias_corner_sel && !chan_a_sleep && !chan_b_sleep
    && !clock_mult_sleep && !skew_loop_sleep)
    else $error("power or scale reset value wrong");

  AST_UNUSED_ZERO: assert property (@(posedge mclk) // [R18]
    disable iff (rst)
    reg_addr == ERROR_STATUS_OFS |=> (reg_rdata & 8'hCF) == 8'h00)
    else $error("unused status bits read nonzero");

  AST_SCALE_WRITE: assert property (@(posedge mclk) // [R14]
    disable iff (rst)
    wr_scale |=> chan_a_current_scale == $past(reg_wdata[7:4])
    && chan_b_current_scale == $past(reg_wdata[3:0]))
    else $error("scale write not applied");

endmodule

// ### dsr_host_model.sv
`timescale 1ns/1ns
module dsr_host_model
  import dsr_pkg::*;
(
  input  wire logic              mclk,
  output      logic              reg_wr_en,
  output      logic [ADDR_W-1:0] reg_addr,
  output      logic [DATA_W-1:0] reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata,
  output      logic [WORD_W-1:0] buf_word,
  output      logic              buf_word_valid
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    buf_word = 16'h0000;
    buf_word_valid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // callers pass reserved bits as zero except the 8'hFF status write in t_overrun
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // read data is registered: it stands from the edge after the address,
  // so it is taken mid-cycle where it has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    d = reg_rdata;
  endtask

  task automatic put(input logic [15:0] w);
    @(posedge mclk);
    buf_word <= w;
    buf_word_valid <= 1'b1;
    @(posedge mclk);
    buf_word_valid <= 1'b0;
    buf_word <= ~w;
  endtask

  // eight good words flush the buffer before the flag is cleared
  task automatic flush_clear();
    for (int i = 0; i < 8; i++)
      put(i[0] ? 16'h5555 : 16'hAAAA);
    wr(8'h04, 8'h00);
  endtask
endmodule

// ### dsr_regs_tb.sv
`timescale 1ns/1ns
module dsr_regs_tb;
  import dsr_pkg::*;
  logic mclk, rst, we, ovr, oem, pem, vld, sev, rsy, fw, skb, cmb;
  logic sla, slb, cra, crb, cms, sks;
  logic [7:0] adr, wd, rdt;
  logic [15:0] bw, raw, map;
  logic [3:0] sca, scb;
  int errors = 0;
  int n_tests = 0;

  dsr_host_model i_dsr_host_model (.mclk(mclk), .reg_wr_en(we),
    .reg_addr(adr), .reg_wdata(wd), .reg_rdata(rdt), .buf_word(bw),
    .buf_word_valid(vld));
  dsr_regs i_dsr_regs (.mclk(mclk), .rst(rst), .reg_wr_en(we),
    .reg_addr(adr), .reg_wdata(wd), .reg_rdata(rdt),
    .overrun_err_mask(oem), .pattern_err_mask(pem), .buf_overrun(ovr),
    .buf_word(bw), .buf_word_valid(vld), .in_bus_raw(raw),
    .in_bus_mapped(map), .sync_event(sev), .divider_resync(rsy),
    .four_wire_serial_select(fw), .skew_loop_bypass(skb),
    .clock_mult_bypass(cmb), .chan_a_sleep(sla), .chan_b_sleep(slb),
    .chan_a_bias_corner_sel(cra), .chan_b_bias_corner_sel(crb),
    .clock_mult_sleep(cms), .skew_loop_sleep(sks),
    .chan_a_current_scale(sca), .chan_b_current_scale(scb));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_dsr_host_model.rd(a, d);
    chk(16'(d), 16'(e));
  endtask

  task automatic wset(input logic [7:0] a, input logic [7:0] d);
    i_dsr_host_model.wr(a, d);
    @(negedge mclk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] e [4] = '{8'h00, 8'h00, 8'h0C, 8'hFF};
    for (int i = 0; i < 4; i++)
      rchk(8'(i + 4), e[i]);
    chk(16'({cra, crb, sla, slb, cms, sks, sca, scb}), 16'h30FF);
    $display("test reset done");
  endtask

  task automatic t_cfg();
    wset(8'h05, 8'hE6);
    chk(16'({fw, skb, cmb}), 16'h0007);
    wset(8'h06, 8'h10);
    chk(16'({cra, crb, sla, slb, cms, sks}), 16'h0008);
    wset(8'h06, 8'h2B);
    chk(16'({cra, crb, sla, slb, cms, sks}), 16'h0027);
    rchk(8'h06, 8'h2B);
    wset(8'h07, 8'h3A);
    chk(16'({sca, scb}), 16'h003A);
    rchk(8'h07, 8'h3A);
    rchk(8'h08, 8'h00);
    wset(8'h05, 8'h00);
    $display("test config done");
  endtask

  task automatic t_mirror_sync();
    wset(8'h05, 8'h40);
    @(posedge mclk) raw <= 16'h1234;
    @(posedge mclk);
    @(negedge mclk) chk(map, 16'h2C48);
    wset(8'h05, 8'h00);
    // the word taken on the write edge still used the old bit order
    @(negedge mclk) chk(map, 16'h1234);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk) sev <= 1'b1;
      @(posedge mclk) sev <= 1'b0;
      @(negedge mclk) chk(16'(rsy), 16'(i == 0));
      wset(8'h05, 8'h20);
    end
    wset(8'h05, 8'h00);
    $display("test mirror and sync done");
  endtask

  task automatic t_overrun();
    @(posedge mclk) oem <= 1'b0;
    @(posedge mclk) ovr <= 1'b1;
    @(posedge mclk) ovr <= 1'b0;
    rchk(8'h04, 8'h20);
    wset(8'h04, 8'hFF);
    rchk(8'h04, 8'h20);
    wset(8'h04, 8'h00);
    rchk(8'h04, 8'h00);
    @(posedge mclk) oem <= 1'b1;
    @(posedge mclk) ovr <= 1'b1;
    @(posedge mclk) ovr <= 1'b0;
    rchk(8'h04, 8'h00);
    $display("test overrun done");
  endtask

  task automatic t_pattern();
    @(posedge mclk) pem <= 1'b0;
    i_dsr_host_model.put(16'hAAAA);
    i_dsr_host_model.put(16'h5555);
    rchk(8'h04, 8'h00);
    i_dsr_host_model.put(16'hAAAB);
    i_dsr_host_model.put(16'h5555);
    rchk(8'h04, 8'h10);
    i_dsr_host_model.flush_clear();
    rchk(8'h04, 8'h00);
    @(posedge mclk) pem <= 1'b1;
    i_dsr_host_model.put(16'h0000);
    rchk(8'h04, 8'h00);
    $display("test pattern done");
  endtask

  // reset after the registers were changed must restore the defaults
  task automatic t_mid_reset();
    wset(8'h07, 8'h00);
    wset(8'h06, 8'h33);
    @(posedge mclk) rst <= 1'b1;
    @(posedge mclk) rst <= 1'b0;
    t_reset();
    $display("test mid-run reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // whole run is about 115 cycles
  initial
  begin
    #50000;
    errors++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    {ovr, sev, raw} = '0;
    {oem, pem} = 2'b11;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_cfg();
    t_mirror_sync();
    t_overrun();
    t_pattern();
    t_mid_reset();
    print_verdict();
  end
endmodule
